// ### nvsg_params.svh
// Offsets, field positions, reset values and addresses of the security gate
`ifndef NVSG_PARAMS_SVH
`define NVSG_PARAMS_SVH

`define NVSG_OFF_WOPT      8'h00
`define NVSG_OFF_WPROT     8'h04
`define NVSG_OFF_KEYHI     8'h08
`define NVSG_OFF_KEYLO     8'h0c
`define NVSG_OFF_CTRL      8'h10
`define NVSG_OFF_STATUS    8'h14

`define NVSG_NV_KEY_BASE   16'hffb0
`define NVSG_NV_PROT       16'hffbd
`define NVSG_NV_OPT        16'hffbf
`define NVSG_KEY_BYTES     4'h8

`define NVSG_OPT_KEY_ENABLE_BIT     7
`define NVSG_OPT_NORED     6
`define NVSG_OPT_SEC_HI    1
`define NVSG_OPT_SEC_LO    0
`define NVSG_SEC_UNSECURE  2'h2
`define NVSG_PROT_PROTECT_DISABLE_BIT    0
`define NVSG_PROT_FPS_HI   7
`define NVSG_PROT_FPS_LO   1

`define NVSG_CTRL_START    0
`define NVSG_ST_SECURE     0
`define NVSG_ST_LOADED     1
`define NVSG_ST_UNLOCKED   2
`define NVSG_ST_KEYFAIL    3
`define NVSG_ST_REFUSED    4

`define NVSG_WOPT_RST      8'h03
`define NVSG_WPROT_RST     8'hff

`endif

// ### nvsg_pkg.sv
// Types shared by the security gate modules
package nvsg_pkg;
  typedef enum {
    LdKey,
    LdProt,
    LdOpt,
    Run
  } nvsg_load_e;
  typedef logic [7:0] nvsg_byte_t;
endpackage

// ### nvsg_ram_if.sv
// Carrier between the gate and its retained RAM
`timescale 1ns/1ps
interface nvsg_ram_if #(
  parameter int AW = 9
);
  logic          req;
  logic          we;
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  logic          allow;
  modport ctrl (output req, output we, output addr, output wdata, output allow, input rdata);
  modport mem  (input req, input we, input addr, input wdata, input allow, output rdata);
endinterface

// ### nvsg_ram.sv
// Retained RAM array behind the security gate
`timescale 1ns/1ps
module nvsg_ram #(
  parameter int AW = 9
) (
  input wire logic  ref_clk,
  nvsg_ram_if.mem   bus
);
  logic [7:0] mem [2**AW];
  logic [7:0] rdata_q;

  if (AW < 1 || AW > 16) begin : g_bad_aw
    $error("nvsg_ram: AW out of range");
  end

  // [R08] Contents never reset
  always_ff @(posedge ref_clk) begin
    if (bus.req && bus.allow && bus.we) begin
      mem[bus.addr] <= bus.wdata;
    end
  end

  // [R07] Blocked reads return zero
  always_ff @(posedge ref_clk) begin
    if (bus.req && !bus.we) begin
      rdata_q <= bus.allow ? mem[bus.addr] : 8'h00;
    end
  end

  assign bus.rdata = rdata_q;
endmodule

// ### nvsg_top.sv
// Nonvolatile security gate: option load, key unlock, access gating
//
// What this block does
// [R01] Every reset reloads stored protection and option bytes into working registers.
// [R02] An 8-byte backdoor key is read from nonvolatile 0xFFB0 to 0xFFB7.
// [R03] Matching key unlocks security only when the key enable bit is one.
// [R04] Key compare accepted only from secure code, never from background debug.
// [R05] Key enable zero disables key; only erase plus blank check unlocks.
// [R06] Security field value 1:0 means unsecured.
// [R07] While secured, debug and non-secure code cannot reach RAM.
// [R08] RAM contents survive low-power modes and every reset.
// [R09] Controller clears a disabled-key lock by mass erase 0x41, then blank check 0x05; this block issues neither and unlocks on blankVerified.
// [R10] Key unlock lasts only until the next reset.
`timescale 1ns/1ps
`include "nvsg_params.svh"
module nvsg_top #(
  parameter int RAM_AW = 9
) (
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output      logic [31:0]       prdata,
  output      logic              pready,
  output      logic              pslverr,
  output      logic              nvmRdReq,
  output      logic [15:0]       nvmAddr,
  input  wire logic [7:0]        nvmRdData,
  input  wire logic              nvmRdValid,
  input  wire logic              execSecure,
  input  wire logic              bdmActive,
  input  wire logic              blankVerified,
  input  wire logic              ramReq,
  input  wire logic              ramWe,
  input  wire logic [RAM_AW-1:0] ramAddr,
  input  wire logic [7:0]        ramWdata,
  input  wire logic              ramFromNonSecure,
  output      logic [7:0]        ramRdata,
  output      logic              ramDenied,
  output      logic              secureEngaged,
  output      logic              flashDebugBlock,
  output      logic              loadDone,
  output      logic [6:0]        protBoundary,
  output      logic              protDisable,
  output      logic              vectorRedirectDisable
);
  nvsg_pkg::nvsg_load_e state_q;
  logic [3:0]           idx_q;
  logic [63:0]          storedKey_q;
  logic [7:0]           workOpt_q;
  logic [7:0]           workProt_q;
  logic [31:0]          keyHi_q;
  logic [31:0]          keyLo_q;
  logic                 unlock_q;
  logic                 keyFail_q;
  logic                 refused_q;
  logic                 ramDenied_q;
  logic                 wrEn;
  logic                 rdEn;
  logic                 startCmp;
  logic                 keyAllowed;
  logic                 fieldUnsecure;
  logic                 ramAllow;

  if (RAM_AW < 1 || RAM_AW > 16) begin : g_bad_aw
    $error("nvsg_top: RAM_AW out of range");
  end

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `NVSG_OFF_WOPT) || (a == `NVSG_OFF_WPROT) || (a == `NVSG_OFF_KEYHI)
          || (a == `NVSG_OFF_KEYLO) || (a == `NVSG_OFF_CTRL) || (a == `NVSG_OFF_STATUS);
  endfunction

  // APB slave answers with no wait state
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign wrEn    = psel && penable && pwrite && mapped(paddr);
  assign rdEn    = psel && penable && !pwrite;

  // [R01] Load sequence after each reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= nvsg_pkg::LdKey;
      idx_q   <= 4'h0;
    end else if (state_q != nvsg_pkg::Run && nvmRdReq && nvmRdValid) begin
      case (state_q)
        nvsg_pkg::LdKey: begin
          idx_q <= idx_q + 4'h1;
          if (idx_q == `NVSG_KEY_BYTES - 4'h1) begin
            state_q <= nvsg_pkg::LdProt;
          end
        end
        nvsg_pkg::LdProt: state_q <= nvsg_pkg::LdOpt;
        nvsg_pkg::LdOpt:  state_q <= nvsg_pkg::Run;
        default:          state_q <= nvsg_pkg::Run;
      endcase
    end
  end

  // [R02] Address of each stored byte
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      nvmAddr  <= `NVSG_NV_KEY_BASE;
      nvmRdReq <= 1'b0;
    end else begin
      nvmRdReq <= (state_q != nvsg_pkg::Run) && !(nvmRdValid && nvmRdReq);
      case (state_q)
        nvsg_pkg::LdKey: nvmAddr <= `NVSG_NV_KEY_BASE + {12'h000, idx_q};
        nvsg_pkg::LdProt: nvmAddr <= `NVSG_NV_PROT;
        nvsg_pkg::LdOpt:  nvmAddr <= `NVSG_NV_OPT;
        default:          nvmAddr <= `NVSG_NV_OPT;
      endcase
    end
  end

  // [R02] Stored key, lowest address most significant
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      storedKey_q <= 64'h0;
    end else if (state_q == nvsg_pkg::LdKey && nvmRdReq && nvmRdValid) begin
      storedKey_q <= {storedKey_q[55:0], nvmRdData};
    end
  end

  // [R01] Working copies of protection and option bytes
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      workProt_q <= `NVSG_WPROT_RST;
      workOpt_q  <= `NVSG_WOPT_RST;
    end else if (nvmRdReq && nvmRdValid) begin
      if (state_q == nvsg_pkg::LdProt) begin
        workProt_q <= nvmRdData;
      end
      if (state_q == nvsg_pkg::LdOpt) begin
        workOpt_q <= nvmRdData;
      end
    end
  end

  // Key entry words
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      keyHi_q <= 32'h0;
      keyLo_q <= 32'h0;
    end else if (wrEn) begin
      if (paddr == `NVSG_OFF_KEYHI) begin
        keyHi_q <= pwdata;
      end
      if (paddr == `NVSG_OFF_KEYLO) begin
        keyLo_q <= pwdata;
      end
    end
  end

  assign startCmp = wrEn && (paddr == `NVSG_OFF_CTRL) && pwdata[`NVSG_CTRL_START];

  // [R04] Only secure code, never debug
  // [R05] Key enable zero blocks the compare
  assign keyAllowed = state_q == nvsg_pkg::Run && workOpt_q[`NVSG_OPT_KEY_ENABLE_BIT]
                   && execSecure && !bdmActive;

  // [R03] Matching key unlocks
  // [R05] Blank check after erase unlocks
  // [R10] Cleared only by reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      unlock_q <= 1'b0;
    end else if ((startCmp && keyAllowed && {keyHi_q, keyLo_q} == storedKey_q)
                 || (blankVerified && state_q == nvsg_pkg::Run)) begin
      unlock_q <= 1'b1;
    end
  end

  // [R04] Mismatch and refusal flags
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      keyFail_q <= 1'b0;
      refused_q <= 1'b0;
    end else if (startCmp) begin
      refused_q <= !keyAllowed;
      keyFail_q <= keyAllowed && ({keyHi_q, keyLo_q} != storedKey_q);
    end
  end

  // [R06] Code 1:0 is unsecured
  assign fieldUnsecure = workOpt_q[`NVSG_OPT_SEC_HI:`NVSG_OPT_SEC_LO] == `NVSG_SEC_UNSECURE;
  assign secureEngaged = !(loadDone && (fieldUnsecure || unlock_q));
  assign flashDebugBlock = secureEngaged;
  assign loadDone = state_q == nvsg_pkg::Run;

  assign protBoundary          = workProt_q[`NVSG_PROT_FPS_HI:`NVSG_PROT_FPS_LO];
  assign protDisable           = workProt_q[`NVSG_PROT_PROTECT_DISABLE_BIT];
  assign vectorRedirectDisable = workOpt_q[`NVSG_OPT_NORED];

  // [R07] RAM gating while secured
  assign ramAllow = !(secureEngaged && (bdmActive || ramFromNonSecure));

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ramDenied_q <= 1'b0;
    end else begin
      ramDenied_q <= ramReq && !ramAllow;
    end
  end
  assign ramDenied = ramDenied_q;

  nvsg_ram_if #(.AW(RAM_AW)) ramBus ();
  assign ramBus.req   = ramReq;
  assign ramBus.we    = ramWe;
  assign ramBus.addr  = ramAddr;
  assign ramBus.wdata = ramWdata;
  assign ramBus.allow = ramAllow;
  assign ramRdata     = ramBus.rdata;

  // [R08] Retained array
  nvsg_ram #(.AW(RAM_AW)) u_ram (
    .ref_clk (ref_clk),
    .bus     (ramBus)
  );

  // Read data register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `NVSG_OFF_WOPT:   prdata <= {24'h0, workOpt_q};
        `NVSG_OFF_WPROT:  prdata <= {24'h0, workProt_q};
        `NVSG_OFF_KEYHI:  prdata <= 32'h0;
        `NVSG_OFF_KEYLO:  prdata <= 32'h0;
        `NVSG_OFF_STATUS: prdata <= {27'h0, refused_q, keyFail_q, unlock_q, loadDone,
                                     secureEngaged};
        default:          prdata <= 32'h0;
      endcase
    end else if (rdEn) begin
      prdata <= prdata;
    end
  end
endmodule

// ### nvsg_top_monitor.sv
// Port checker of the security gate
`timescale 1ns/1ps
module nvsg_top_monitor (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        nvmRdReq,
  input wire logic        nvmRdValid,
  input wire logic [15:0] nvmAddr,
  input wire logic        bdmActive,
  input wire logic        blankVerified,
  input wire logic        ramReq,
  input wire logic        ramWe,
  input wire logic        ramFromNonSecure,
  input wire logic [7:0]  ramRdata,
  input wire logic        ramDenied,
  input wire logic        secureEngaged,
  input wire logic        flashDebugBlock,
  input wire logic        loadDone
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic blk;
  assign blk = ramReq && secureEngaged && (bdmActive || ramFromNonSecure);
  a_ram_blocked: assert property (
    blk |=> ramDenied) else $error("ram not blocked");
  a_ram_zero: assert property (
    blk && !ramWe |=> ramRdata == 8'h00) else $error("blocked read not zero");
  a_ram_allowed: assert property (
    ramReq && !blk |=> !ramDenied) else $error("ram wrongly blocked");
  a_debug_follow: assert property (
    flashDebugBlock == secureEngaged) else $error("debug block differs");
  a_secure_preload: assert property (
    !loadDone |-> secureEngaged) else $error("open before load");
  a_load_kept: assert property (
    loadDone |=> loadDone) else $error("load done dropped");
  a_open_kept: assert property (
    loadDone && !secureEngaged |=> !secureEngaged) else $error("security re-engaged");
  a_flash_hold: assert property (
    nvmRdReq && !nvmRdValid |=> nvmRdReq && $stable(nvmAddr)) else $error("read not held");
  a_flash_range: assert property (
    nvmRdReq |-> nvmAddr inside {[16'hffb0:16'hffb7], 16'hffbd, 16'hffbf})
    else $error("read address off");
  a_bdm_no_key: assert property (
    psel && penable && pwrite && paddr == 8'h10 && pwdata[0] && bdmActive && secureEngaged
    && !blankVerified |=> secureEngaged) else $error("debug key unlock");
endmodule

bind nvsg_top nvsg_top_monitor i_mon (.*);

// ### nvsg_flash_model.sv
// Flash array model answering the gate's byte reads
`timescale 1ns/1ps
module nvsg_flash_model #(
  parameter logic [63:0] KEY  = 64'h0123456789abcdef,
  parameter logic [7:0]  PROT = 8'h5a
) (
  input  wire logic        ref_clk,
  input  wire logic        nvmRdReq,
  input  wire logic [15:0] nvmAddr,
  input  wire logic [7:0]  opt,
  input  wire logic [3:0]  dly,
  output      logic        nvmRdValid,
  output      logic [7:0]  nvmRdData
);
  logic [3:0] cnt = 4'h0;
  initial nvmRdValid = 1'b0;
  initial nvmRdData = 8'h00;
  function automatic logic [7:0] rd(input logic [15:0] a);
    if (a[15:3] == 13'h1ff6) return KEY[63 - 8 * a[2:0] -: 8];
    if (a == 16'hffbd) return PROT;
    if (a == 16'hffbf) return opt;
    return 8'hff;
  endfunction
  always @(posedge ref_clk) begin
    nvmRdValid <= 1'b0;
    nvmRdData <= ~nvmRdData;
    if (nvmRdReq && !nvmRdValid) begin
      if (cnt == dly) begin
        nvmRdValid <= 1'b1;
        nvmRdData <= rd(nvmAddr);
        cnt <= 4'h0;
      end else cnt <= cnt + 4'h1;
    end
  end
endmodule

// ### nvsg_top_bench.sv
// Self-checking bench of the security gate
`timescale 1ns/1ps
module nvsg_top_bench;
  localparam logic [63:0] K = 64'h0123456789abcdef;
  logic        ref_clk = '0, arst_n = '0, psel = '0, penable = '0, pwrite = '0, ramReq = '0;
  logic        execSecure = '0, bdmActive = '0, blankVerified = '0, ramWe = '0, e;
  logic        ramFromNonSecure = '0;
  logic [7:0]  paddr = '0, ramWdata = '0, opt = 8'h83, ramRdata, nvmRdData;
  logic [8:0]  ramAddr = 9'h003;
  logic [3:0]  dly = 4'h3;
  logic [31:0] pwdata = '0, r, prdata;
  logic        nvmRdReq, nvmRdValid, pready, pslverr, ramDenied, secureEngaged;
  logic        flashDebugBlock, loadDone, protDisable, vectorRedirectDisable;
  logic [6:0]  protBoundary;
  logic [15:0] nvmAddr;
  int          n_errors = 0, n_tests = 0;
  always #5 ref_clk = ~ref_clk;
  nvsg_top #(.RAM_AW(9)) i_dut (.*);
  nvsg_flash_model i_flash (.*);
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    report_and_stop();
  endtask
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) hang();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst(input logic [7:0] o);
    int i;
    @(posedge ref_clk);
    opt <= o;
    arst_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (i = 0; i < 400 && loadDone !== 1'b1; i++) @(posedge ref_clk);
    if (i == 400) hang();
  endtask
  task automatic ram(input logic w, input logic ns, input logic bd, input logic [7:0] d);
    @(posedge ref_clk);
    ramReq <= 1'b1;
    ramWe <= w;
    ramFromNonSecure <= ns;
    bdmActive <= bd;
    ramWdata <= d;
    @(posedge ref_clk);
    ramReq <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic key(input logic [63:0] k, input logic es, input logic bd);
    @(posedge ref_clk);
    execSecure <= es;
    bdmActive <= bd;
    apb(1'b1, 8'h08, k[63:32]);
    apb(1'b1, 8'h0c, k[31:0]);
    apb(1'b1, 8'h10, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
  endtask
  task automatic t_load();
    rst(8'h83);
    apb(1'b0, 8'h00, 32'h0);
    chk("wopt", r, 32'h83);
    apb(1'b0, 8'h04, 32'h0);
    chk("wprot", r, 32'h5a);
    chk("bound", 32'(protBoundary), 32'h2d);
    chk("pdis", 32'(protDisable), 32'h0);
    chk("vrd0", 32'(vectorRedirectDisable), 32'h0);
    chk("sec", 32'(secureEngaged), 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk("slverr", 32'(e), 32'h1);
    ram(1'b1, 1'b1, 1'b0, 8'h55);
    chk("nsdeny", 32'(ramDenied), 32'h1);
    ram(1'b0, 1'b0, 1'b1, 8'h00);
    chk("bddeny", 32'(ramDenied), 32'h1);
    $display("load and gate test done");
  endtask
  task automatic t_key();
    key(K, 1'b1, 1'b1);
    chk("bdkey", r[4:0], 32'h13);
    key(K, 1'b0, 1'b0);
    chk("nskey", r[4:0], 32'h13);
    key(K ^ 64'h1, 1'b1, 1'b0);
    chk("badkey", r[4:0], 32'h0b);
    key(K, 1'b1, 1'b0);
    chk("goodkey", r[4:0], 32'h06);
    chk("open", 32'(secureEngaged), 32'h0);
    ram(1'b1, 1'b1, 1'b0, 8'ha5);
    ram(1'b0, 1'b1, 1'b1, 8'h00);
    chk("openram", 32'(ramRdata), 32'ha5);
    rst(8'h83);
    chk("relock", 32'(secureEngaged), 32'h1);
    ram(1'b0, 1'b0, 1'b0, 8'h00);
    chk("kept", 32'(ramRdata), 32'ha5);
    $display("key test done");
  endtask
  task automatic t_nokey();
    dly <= 4'h0;
    rst(8'h03);
    key(K, 1'b1, 1'b0);
    chk("nokey", r[4:0], 32'h13);
    blankVerified <= 1'b1;
    @(posedge ref_clk);
    blankVerified <= 1'b0;
    @(negedge ref_clk);
    chk("blank", 32'(secureEngaged), 32'h0);
    rst(8'h42);
    chk("unsec", 32'(secureEngaged), 32'h0);
    chk("vrd1", 32'(vectorRedirectDisable), 32'h1);
    $display("no key test done");
  endtask
  initial begin
    t_load();
    t_key();
    t_nokey();
    report_and_stop();
  end
endmodule
